/* smx_pkg.sv */
// constants, types and tables for the spectral mux sequencer
// Behaviour
// (R1) command field bits 4:3, reset 2, runs on enable
// (R2) command 0 loads chain from rom
// (R3) command 1 reads chain into config ram
// (R4) command 2 writes config ram into chain
// (R5) host avoids command 3 and changes mid-operation
// (R6) done irq enable bit 4 gates interrupt
// (R7) readout field bits 6:5, reset 0, one cycle
// (R8) readout 2 runs two cycles, 1 reserved
// (R9) readout 3 runs three cycles
// (R10) host changes readout field only when idle
// (R11) cycles run unattended into eighteen result slots
// (R12) photopic pair uses top-left and bottom-right diodes
// (R13) host clears bank select before access
// (R14) done indication held until host acknowledges
package smx_pkg;
  localparam logic [7:0] SMX_OFS_IRQ_CFG  = 8'h00ca;
  localparam logic [7:0] SMX_OFS_AUTO_CFG = 8'h00d6;
  localparam logic [7:0] SMX_OFS_CMD_CFG  = 8'h00f5;
  localparam int         SMX_CMD_LSB      = 3;
  localparam int         SMX_IRQ_EN_BIT   = 4;
  localparam int         SMX_AUTO_LSB     = 5;
  localparam logic [1:0] SMX_CMD_RESET    = 2'h2;
  localparam logic [1:0] SMX_AUTO_RESET   = 2'h0;
  localparam logic       SMX_IRQ_RESET    = 1'b0;
  localparam logic [1:0] SMX_CMD_ROM_INIT = 2'h0;
  localparam logic [1:0] SMX_CMD_READ     = 2'h1;
  localparam logic [1:0] SMX_CMD_WRITE    = 2'h2;
  localparam logic [1:0] SMX_AUTO_TWO     = 2'h2;
  localparam logic [1:0] SMX_AUTO_THREE   = 2'h3;
  localparam int         SMX_CHAIN_BYTES  = 16;
  localparam logic [3:0] SMX_LAST_BYTE    = 4'hf;
  localparam logic [2:0] SMX_LAST_BIT     = 3'h7;
  localparam int         SMX_SLOTS        = 6;
  localparam logic [2:0] SMX_LAST_SLOT    = 3'h5;
  localparam int         SMX_RESULTS      = 18;

  typedef enum logic [3:0] {
    SMX_CH_FILTER_ONE   = 4'h0,
    SMX_CH_FILTER_TWO   = 4'h1,
    SMX_CH_FILTER_THREE = 4'h2,
    SMX_CH_FILTER_FOUR  = 4'h3,
    SMX_CH_FILTER_FIVE  = 4'h4,
    SMX_CH_FILTER_SIX   = 4'h5,
    SMX_CH_FILTER_SEVEN = 4'h6,
    SMX_CH_FILTER_EIGHT = 4'h7,
    SMX_CH_FILTER_Z     = 4'h8,
    SMX_CH_FILTER_Y     = 4'h9,
    SMX_CH_FILTER_XL    = 4'ha,
    SMX_CH_NEAR_INFRA   = 4'hb,
    SMX_CH_PAIR_TL_BR   = 4'hc,
    SMX_CH_CLEAR        = 4'hd
  } smx_chan_t;

  // channel converted in each slot of each cycle
  function automatic smx_chan_t smx_slot_chan(input logic [1:0] cyc, input logic [2:0] slot);
    smx_chan_t ch;
    ch = SMX_CH_CLEAR;
    if (slot == 3'h4) begin
      ch = SMX_CH_PAIR_TL_BR; // (R12)
    end else if (slot < 3'h4) begin
      unique case (cyc)
        2'h1: ch = smx_chan_t'(slot == 3'h3 ? 4'h5 : {1'b0, slot} + 4'h1); // (R8)
        2'h2: ch = smx_chan_t'(slot == 3'h0 ? 4'h0 :
                               slot == 3'h1 ? 4'h4 : {1'b0, slot} + 4'h4); // (R9)
        default: ch = smx_chan_t'({1'b1, slot[2:0]}); // (R7)
      endcase
    end
    return ch;
  endfunction

  // built-in chain default, value arbitrary
  function automatic logic [7:0] smx_rom_byte(input logic [3:0] idx);
    return {idx, ~idx};
  endfunction
endpackage

/* smx_mem.sv */
// small synchronous memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module smx_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output var  logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule // smx_mem
`default_nettype wire

/* smx_sequencer.sv */
// mux chain command engine, readout sequencer and config registers
`timescale 1ns/1ns
`default_nettype none
module smx_sequencer
  import smx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [7:0]  reg_rdata,
  input  wire logic        spectral_enable,
  input  wire logic        mux_done_ack,
  output logic             mux_busy,
  output logic             mux_done,
  output logic             sys_irq,
  output logic             chain_shift,
  output logic             chain_dout,
  input  wire logic        chain_din,
  output logic             chain_latch,
  input  wire logic        meas_start,
  output logic             meas_busy,
  output logic             conv_start,
  output logic      [3:0]  conv_channel,
  output logic      [1:0]  conv_cycle,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  input  wire logic [4:0]  result_addr,
  output logic      [15:0] result_data
);
  typedef enum logic [5:0] {
    SMX_M_IDLE  = 6'b000001,
    SMX_M_FETCH = 6'b000010,
    SMX_M_LOAD  = 6'b000100,
    SMX_M_SHIFT = 6'b001000,
    SMX_M_STORE = 6'b010000,
    SMX_M_DONE  = 6'b100000
  } smx_mstate_t;

  typedef enum logic [2:0] {
    SMX_R_IDLE  = 3'b001,
    SMX_R_START = 3'b010,
    SMX_R_WAIT  = 3'b100
  } smx_rstate_t;

  logic [1:0]  cmd_reg;
  logic [1:0]  auto_reg;
  logic        irq_en_reg;
  logic [1:0]  run_cmd_reg;
  logic        en_d_reg;
  smx_mstate_t mstate_reg;
  logic [3:0]  byte_idx_reg;
  logic [2:0]  bit_idx_reg;
  logic [7:0]  sh_reg;
  logic [7:0]  ram_rdata;
  logic        ram_we;
  logic [7:0]  ram_wdata;
  smx_rstate_t rstate_reg;
  logic [1:0]  last_cyc_reg;
  logic [2:0]  slot_reg;
  logic [4:0]  res_idx_reg;
  logic        res_we;
  logic        mux_fin;

  // configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_reg    <= SMX_CMD_RESET; // (R1)
      auto_reg   <= SMX_AUTO_RESET; // (R7)
      irq_en_reg <= SMX_IRQ_RESET;
    end else if (reg_we) begin
      if (reg_addr == SMX_OFS_CMD_CFG) begin
        cmd_reg <= reg_wdata[SMX_CMD_LSB +: 2]; // (R1)
      end
      if (reg_addr == SMX_OFS_AUTO_CFG) begin
        auto_reg <= reg_wdata[SMX_AUTO_LSB +: 2]; // (R7)
      end
      if (reg_addr == SMX_OFS_IRQ_CFG) begin
        irq_en_reg <= reg_wdata[SMX_IRQ_EN_BIT]; // (R6)
      end
    end
  end

  // register read, reserved bits and unmapped offsets as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      reg_rdata <= 8'h00;
      if (reg_addr == SMX_OFS_CMD_CFG) begin
        reg_rdata[SMX_CMD_LSB +: 2] <= cmd_reg;
      end
      if (reg_addr == SMX_OFS_AUTO_CFG) begin
        reg_rdata[SMX_AUTO_LSB +: 2] <= auto_reg;
      end
      if (reg_addr == SMX_OFS_IRQ_CFG) begin
        reg_rdata[SMX_IRQ_EN_BIT] <= irq_en_reg;
      end
    end
  end

  // enable edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= spectral_enable;
    end
  end

  // mux chain command engine
  always_ff @(posedge clk) begin
    if (rst) begin
      mstate_reg   <= SMX_M_IDLE;
      run_cmd_reg  <= SMX_CMD_RESET;
      byte_idx_reg <= 4'h0;
      bit_idx_reg  <= 3'h0;
      sh_reg       <= 8'h00;
    end else begin
      unique case (mstate_reg)
        SMX_M_IDLE: begin
          byte_idx_reg <= 4'h0;
          bit_idx_reg  <= 3'h0;
          if (spectral_enable && !en_d_reg) begin
            run_cmd_reg <= cmd_reg; // (R1)
            mstate_reg  <= (cmd_reg == SMX_CMD_READ) ? SMX_M_SHIFT : SMX_M_FETCH; // (R3)
          end
        end
        SMX_M_FETCH: mstate_reg <= SMX_M_LOAD;
        SMX_M_LOAD: begin
          if (run_cmd_reg == SMX_CMD_ROM_INIT) begin
            sh_reg <= smx_rom_byte(byte_idx_reg); // (R2)
          end else begin
            sh_reg <= ram_rdata; // (R4)
          end
          mstate_reg <= SMX_M_SHIFT;
        end
        SMX_M_SHIFT: begin
          sh_reg      <= {sh_reg[6:0], chain_din}; // (R3)
          bit_idx_reg <= bit_idx_reg + 3'h1;
          if (bit_idx_reg == SMX_LAST_BIT) begin
            mstate_reg <= SMX_M_STORE;
          end
        end
        SMX_M_STORE: begin
          byte_idx_reg <= byte_idx_reg + 4'h1;
          if (byte_idx_reg == SMX_LAST_BYTE) begin
            mstate_reg <= SMX_M_DONE;
          end else if (run_cmd_reg == SMX_CMD_READ) begin
            mstate_reg <= SMX_M_SHIFT;
          end else begin
            mstate_reg <= SMX_M_FETCH;
          end
        end
        SMX_M_DONE: mstate_reg <= SMX_M_IDLE;
        default: mstate_reg <= SMX_M_IDLE;
      endcase
    end
  end

  assign ram_we  = (mstate_reg == SMX_M_STORE) && (run_cmd_reg == SMX_CMD_READ); // (R3)
  assign mux_fin = (mstate_reg == SMX_M_DONE);
  // last chain bit arrives on the store edge
  assign ram_wdata = {sh_reg[6:0], chain_din}; // (R3)

  smx_mem #(.WIDTH(8), .DEPTH(SMX_CHAIN_BYTES), .AW(4)) u_cfg_ram (
    .clk   (clk),
    .we    (ram_we),
    .waddr (byte_idx_reg),
    .wdata (ram_wdata),
    .raddr (byte_idx_reg),
    .rdata (ram_rdata)
  );

  // chain pins
  always_ff @(posedge clk) begin
    if (rst) begin
      chain_shift <= 1'b0;
      chain_dout  <= 1'b0;
      chain_latch <= 1'b0;
      mux_busy    <= 1'b0;
    end else begin
      chain_shift <= (mstate_reg == SMX_M_SHIFT);
      chain_dout  <= sh_reg[7]; // (R4)
      chain_latch <= mux_fin && (run_cmd_reg != SMX_CMD_READ); // (R2)
      mux_busy    <= (mstate_reg != SMX_M_IDLE) && !mux_fin;
    end
  end

  // done flag and interrupt, set wins over acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      mux_done <= 1'b0;
      sys_irq  <= 1'b0;
    end else begin
      if (mux_fin) begin
        mux_done <= 1'b1; // (R14)
      end else if (mux_done_ack) begin
        mux_done <= 1'b0; // (R14)
      end
      sys_irq <= (mux_done || mux_fin) && irq_en_reg && !(mux_done_ack && !mux_fin); // (R6)
    end
  end

  // automatic readout sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      rstate_reg   <= SMX_R_IDLE;
      last_cyc_reg <= 2'h0;
      conv_cycle   <= 2'h0;
      slot_reg     <= 3'h0;
      res_idx_reg  <= 5'h00;
    end else begin
      unique case (rstate_reg)
        SMX_R_IDLE: begin
          conv_cycle  <= 2'h0;
          slot_reg    <= 3'h0;
          res_idx_reg <= 5'h00;
          if (meas_start) begin
            unique case (auto_reg)
              SMX_AUTO_TWO:   last_cyc_reg <= 2'h1; // (R8)
              SMX_AUTO_THREE: last_cyc_reg <= 2'h2; // (R9)
              default:        last_cyc_reg <= 2'h0; // (R7)
            endcase
            rstate_reg <= SMX_R_START;
          end
        end
        SMX_R_START: rstate_reg <= SMX_R_WAIT;
        SMX_R_WAIT: begin
          if (conv_done) begin
            res_idx_reg <= res_idx_reg + 5'h01; // (R11)
            if (slot_reg != SMX_LAST_SLOT) begin
              slot_reg   <= slot_reg + 3'h1;
              rstate_reg <= SMX_R_START;
            end else if (conv_cycle != last_cyc_reg) begin
              slot_reg   <= 3'h0;
              conv_cycle <= conv_cycle + 2'h1; // (R11)
              rstate_reg <= SMX_R_START;
            end else begin
              rstate_reg <= SMX_R_IDLE;
            end
          end
        end
        default: rstate_reg <= SMX_R_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conv_start   <= 1'b0;
      conv_channel <= 4'h0;
      meas_busy    <= 1'b0;
    end else begin
      conv_start   <= (rstate_reg == SMX_R_START);
      conv_channel <= smx_slot_chan(conv_cycle, slot_reg); // (R12)
      meas_busy    <= (rstate_reg != SMX_R_IDLE);
    end
  end

  assign res_we = (rstate_reg == SMX_R_WAIT) && conv_done;

  smx_mem #(.WIDTH(16), .DEPTH(SMX_RESULTS), .AW(5)) u_results (
    .clk   (clk),
    .we    (res_we),
    .waddr (res_idx_reg),
    .wdata (conv_data),
    .raddr (result_addr),
    .rdata (result_data)
  );
endmodule // smx_sequencer
`default_nettype wire

/* smx_sequencer_checker.sv */
// port assertions for the spectral mux sequencer
`timescale 1ns/1ns
`default_nettype none
module smx_sequencer_checker
  import smx_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic       spectral_enable,
  input wire logic       mux_done_ack,
  input wire logic       mux_busy,
  input wire logic       mux_done,
  input wire logic       sys_irq,
  input wire logic       chain_shift,
  input wire logic       chain_latch,
  input wire logic       meas_start,
  input wire logic       meas_busy,
  input wire logic       conv_start,
  input wire logic [3:0] conv_channel,
  input wire logic [1:0] conv_cycle
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  done_held_a: assert property (mux_done && !mux_done_ack |=> mux_done)
    else $error("done flag dropped without ack");
  irq_cause_a: assert property (sys_irq |-> mux_done)
    else $error("interrupt without done flag");
  cmd_launch_a: assert property ($rose(spectral_enable) && !mux_busy |-> ##[1:2] mux_busy)
    else $error("enable edge launched nothing");
  cmd_span_a: assert property ($rose(mux_busy) |-> ##[140:180] !mux_busy)
    else $error("command length out of range");
  shift_busy_a: assert property (chain_shift |-> mux_busy)
    else $error("chain shift while idle");
  latch_end_a: assert property (chain_latch |-> mux_done && !mux_busy)
    else $error("latch outside completion");
  conv_lead_a: assert property (meas_start && !meas_busy && !$past(meas_start) |-> ##2 conv_start)
    else $error("readout did not start");
  conv_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion request not a pulse");
  conv_code_a: assert property (conv_start |-> conv_cycle <= 2'h2 && conv_channel <= 4'hd)
    else $error("bad channel or cycle code");
  third_cycle_chan_a: assert property (conv_start && conv_cycle == 2'h2 |->
    conv_channel inside {4'h0, 4'h4, 4'h6, 4'h7, 4'hc, 4'hd})
    else $error("wrong channel in third cycle");
  cmd_bits_a: assert property (reg_re && reg_addr == SMX_OFS_CMD_CFG |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved command bits not zero");
  cover property (chain_latch);
  cover property (sys_irq);
  cover property (conv_start && conv_cycle == 2'h2);
endmodule // smx_sequencer_checker
`default_nettype wire

/* smx_far_model.sv */
// converter and mux chain stand-in on the far side
`timescale 1ns/1ns
`default_nettype none
module smx_far_model (
  input  wire logic        clk,
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_channel,
  input  wire logic [1:0]  conv_cycle,
  input  wire logic [3:0]  conv_wait,
  input  wire logic [7:0]  conv_tag,
  output logic             conv_done,
  output logic      [15:0] conv_data,
  input  wire logic        chain_shift,
  input  wire logic        chain_dout,
  output logic             chain_din
);
  logic [127:0] chain_reg = '0;
  logic [15:0]  data_reg  = '0;
  logic [3:0]   wait_reg  = '0;
  logic         run_reg   = 1'b0;
  initial conv_done = 1'b0;
  // data only valid with done, inverted otherwise
  assign conv_data = conv_done ? data_reg : ~data_reg;
  assign chain_din = chain_shift ? chain_reg[127] : ~chain_reg[127];
  always @(posedge clk) begin
    conv_done <= 1'b0;
    if (conv_start) begin
      run_reg  <= 1'b1;
      wait_reg <= conv_wait;
      data_reg <= {conv_tag, 2'h0, conv_cycle, conv_channel};
    end else if (run_reg && wait_reg == 4'h0) begin
      run_reg   <= 1'b0;
      conv_done <= 1'b1;
    end else if (run_reg) begin
      wait_reg <= wait_reg - 4'h1;
    end
  end
  always @(posedge clk) begin
    if (chain_shift) begin
      chain_reg <= {chain_reg[126:0], chain_dout};
    end
  end
endmodule // smx_far_model
`default_nettype wire

/* spectral_mux_sequencer_tb.sv */
// self-checking bench for the spectral mux sequencer
`timescale 1ns/1ns
`default_nettype none
module spectral_mux_sequencer_tb;
  import smx_pkg::*;
  logic        clk, rst, reg_we, reg_re, spectral_enable, mux_done_ack, meas_start;
  logic        mux_busy, mux_done, sys_irq, chain_shift, chain_dout, chain_din;
  logic        chain_latch, meas_busy, conv_start, conv_done;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, conv_tag;
  logic [3:0]  conv_channel, conv_wait;
  logic [1:0]  conv_cycle;
  logic [15:0] conv_data, result_data;
  logic [4:0]  result_addr;
  int          errors, num_checks, i;
  logic [23:0] rows [7] = '{24'hf5_ef08, 24'hf5_0000, 24'hca_ff10, 24'hca_0000,
                            24'hd6_ff60, 24'hd6_0000, 24'h10_ff00};
  logic [3:0]  chan_tab [18] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'h1, 4'h2, 4'h3,
                                 4'h5, 4'hc, 4'hd, 4'h0, 4'h4, 4'h6, 4'h7, 4'hc, 4'hd};
  smx_sequencer u_smx_sequencer (.*);
  smx_far_model u_smx_far_model (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge clk);
    reg_re = 1'b0;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic mux_run(input logic [1:0] cmd, input logic irq_en);
    int n;
    wr(SMX_OFS_IRQ_CFG, {3'h0, irq_en, 4'h0});
    wr(SMX_OFS_CMD_CFG, {3'h0, cmd, 3'h0});
    @(negedge clk);
    spectral_enable = 1'b1;
    for (n = 0; n < 400 && mux_done !== 1'b1; n++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk({14'h0, mux_done, sys_irq}, {14'h0, 1'b1, irq_en});
    mux_done_ack = 1'b1;
    spectral_enable = 1'b0;
    @(negedge clk);
    mux_done_ack = 1'b0;
    @(negedge clk);
    chk({14'h0, mux_done, sys_irq}, 16'h0000);
  endtask
  task automatic readout(input logic [1:0] auto, input logic [3:0] w, input logic [7:0] tag);
    int n;
    int k;
    wr(SMX_OFS_AUTO_CFG, {1'b0, auto, 5'h00});
    conv_wait = w;
    conv_tag = tag;
    meas_start = 1'b1;
    @(negedge clk);
    meas_start = 1'b0;
    repeat (3) @(negedge clk);
    for (n = 0; n < 2000 && meas_busy === 1'b1; n++) @(negedge clk);
    for (k = 0; k < 6 * (auto == 2'h0 ? 1 : int'(auto)); k++) begin
      result_addr = 5'(k);
      @(negedge clk);
      chk(result_data, {tag, 2'h0, 2'(k / 6), chan_tab[k]});
    end
  endtask
  initial begin
    {rst, reg_we, reg_re, spectral_enable, mux_done_ack, meas_start} = 6'h20;
    {reg_addr, reg_wdata, conv_tag, conv_wait, result_addr} = '0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rdc(SMX_OFS_CMD_CFG, 8'h10);
    rdc(SMX_OFS_IRQ_CFG, 8'h00);
    rdc(SMX_OFS_AUTO_CFG, 8'h00);
    for (i = 0; i < 7; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    mux_run(SMX_CMD_ROM_INIT, 1'b1);
    for (i = 0; i < 16; i++) chk(u_smx_far_model.chain_reg[127-8*i -: 8], {i[3:0], ~i[3:0]});
    u_smx_far_model.chain_reg = {4{32'hc3a5_0f96}};
    mux_run(SMX_CMD_READ, 1'b0);
    u_smx_far_model.chain_reg = '0;
    mux_run(SMX_CMD_WRITE, 1'b1);
    for (i = 0; i < 8; i++) chk(u_smx_far_model.chain_reg[i*16 +: 16], i[0] ? 16'hc3a5 : 16'h0f96);
    readout(2'h0, 4'h0, 8'h11);
    readout(2'h2, 4'h5, 8'h22);
    readout(2'h3, 4'h1, 8'h33);
    spectral_enable = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b1;
    spectral_enable = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({15'h0, mux_busy}, 16'h0000);
    rdc(SMX_OFS_AUTO_CFG, 8'h00);
    rdc(SMX_OFS_IRQ_CFG, 8'h00);
    close_out();
  end
  initial begin
    #200_000;
    errors++;
    close_out();
  end
endmodule // spectral_mux_sequencer_tb
bind smx_sequencer smx_sequencer_checker u_smx_sequencer_checker (.*);
`default_nettype wire
